// [pm_consts.svh]
// Named constants for the port C / port D alternate-function override.
// Assumes it is included by bare name from the package and the module.
`ifndef PM_CONSTS_SVH
`define PM_CONSTS_SVH

// ****************
// Pin positions in the combined 16-bit pin vector (C low, D high)
// ****************
`define PM_NPINS 16
`define PM_SCL 0
`define PM_SDA 1
`define PM_TCLK 2
`define PM_TMSEL 3
`define PM_TDOUT 4
`define PM_TDIN 5
`define PM_OSC_IN 6
`define PM_OSC_OUT 7
`define PM_RXD 8
`define PM_TXD 9
`define PM_IRQ0 10
`define PM_IRQ1 11
`define PM_CMP1B 12
`define PM_CMP1A 13
`define PM_CAPT 14
`define PM_CMP2 15
`define PM_PORT_W 8

// ****************
// Spike filter timing
// ****************
`define PM_CLK_NS 25
`define PM_SPIKE_NS 50
`define PM_SPIKE_CYC ((`PM_SPIKE_NS + `PM_CLK_NS - 1) / `PM_CLK_NS)
`define PM_FILT_W 4

// ****************
// Reset values
// ****************
`define PM_RST_VEC 16'h0000
`define PM_RST_TWO 2'h0

`endif

// [pm_pkg.sv]
// Types shared by the pin override logic.
// Assumes pm_consts.svh is reachable on the include path.
`include "pm_consts.svh"

package pm_pkg;

    // ****************
    // Whole state of the override block, one packed struct
    // ****************
    typedef struct packed {
        logic [`PM_NPINS-1:0] sync1;   // First synchroniser stage
        logic [`PM_NPINS-1:0] sync2;   // Second synchroniser stage
        logic [1:0] twi_val;           // Filtered clock/data levels
        logic [1:0][`PM_FILT_W-1:0] twi_cnt; // Filter run counters
        logic [`PM_NPINS-1:0] pad_out; // Registered pad output value
        logic [`PM_NPINS-1:0] pad_oe;  // Registered pad drive enable
        logic [`PM_NPINS-1:0] pad_pu;  // Registered pull-up enable
        logic [`PM_NPINS-1:0] din;     // Gated digital input levels
    } pm_state_type;

endpackage

// [pm_port_cd_override.sv]
// Alternate-function override for port C and port D pins.
// Assumes port registers and peripheral signals come from logic on
// clk_sys, and pad inputs arrive asynchronously from the package.
`timescale 1ns/1ps
`include "pm_consts.svh"

// Notes on behaviour
// - Test port takes C2 as test clock
// - Two-wire enable takes C1 as data line
// - Two-wire enable takes C0 as clock line
// - Two-wire inputs reject pulses under 50 ns
// - Two-wire pins open-drain, outputs steer direction
// - Two-wire pull-up follows port bit, not disabled
// - Async timer clock gives C7/C6 to oscillator
// - Data-in pulled up; data-out drives when shifting
// - Mode-select, test clock: pulled-up analog-path inputs
// - Timer 2 compare replaces D7 output value
// - Timer 1 compares replace D5, D4 values
// - D6 digital input feeds timer 1 capture
// - External interrupts force D2/D3 inputs on
// - Transmitter forces D1 output, no pull-up
// - Receiver forces D0 input, delivers receive data
// - Receive pull-up follows port bit, not disabled
// - Global pull-up disable turns off port pull-ups, except on the test-port input pins
module pm_port_cd_override
    import pm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    // Port register bits
    input wire logic [`PM_PORT_W-1:0] portc_out,
    input wire logic [`PM_PORT_W-1:0] portc_dir,
    input wire logic [`PM_PORT_W-1:0] portd_out,
    input wire logic [`PM_PORT_W-1:0] portd_dir,
    input wire logic global_pullup_disable,
    // Peripheral enables
    input wire logic timer2_async_select,
    input wire logic test_port_enable,
    input wire logic shift_instr_state,
    input wire logic shift_data_state,
    input wire logic two_wire_enable,
    input wire logic timer2_compare_en,
    input wire logic timer1_compare_a_en,
    input wire logic timer1_compare_b_en,
    input wire logic ext_irq0_en,
    input wire logic ext_irq1_en,
    input wire logic transmitter_enable,
    input wire logic receiver_enable,
    // Peripheral output values
    input wire logic test_data_out,
    input wire logic two_wire_data_out,
    input wire logic two_wire_clock_out,
    input wire logic timer2_compare_out,
    input wire logic timer1_compare_a_out,
    input wire logic timer1_compare_b_out,
    input wire logic transmit_data,
    // Pads
    input wire logic [`PM_PORT_W-1:0] padc_in,
    input wire logic [`PM_PORT_W-1:0] padd_in,
    output logic [`PM_PORT_W-1:0] padc_out,
    output logic [`PM_PORT_W-1:0] padc_oe,
    output logic [`PM_PORT_W-1:0] padc_pullup,
    output logic [`PM_PORT_W-1:0] padd_out,
    output logic [`PM_PORT_W-1:0] padd_oe,
    output logic [`PM_PORT_W-1:0] padd_pullup,
    // Pin levels seen by the port read path
    output logic [`PM_PORT_W-1:0] portc_pin,
    output logic [`PM_PORT_W-1:0] portd_pin,
    // Peripheral inputs
    output logic test_clock_in,
    output logic test_mode_in,
    output logic test_data_in,
    output logic two_wire_data_in,
    output logic two_wire_clock_in,
    output logic timer_osc_in,
    output logic timer1_capture_in,
    output logic ext_irq0_in,
    output logic ext_irq1_in,
    output logic receive_data
);

    // ****************
    // State and next state
    // ****************
    pm_state_type st_q; // Registered state
    pm_state_type st_d; // Next state

    // Per-pin override enables and values
    logic [`PM_NPINS-1:0] pullup_override_en;
    logic [`PM_NPINS-1:0] pullup_override_val;
    logic [`PM_NPINS-1:0] dir_override_en;
    logic [`PM_NPINS-1:0] dir_override_val;
    logic [`PM_NPINS-1:0] outval_override_en;
    logic [`PM_NPINS-1:0] outval_override_val;
    logic [`PM_NPINS-1:0] input_enable_override_en;
    logic [`PM_NPINS-1:0] input_enable_override_val;

    // Combined register views and pad input
    logic [`PM_NPINS-1:0] reg_out;  // Port output bits, C then D
    logic [`PM_NPINS-1:0] reg_dir;  // Port direction bits, C then D
    logic [`PM_NPINS-1:0] pad_in;   // Raw asynchronous pad levels

    // Final per-pin controls before registering
    logic [`PM_NPINS-1:0] fin_pu;
    logic [`PM_NPINS-1:0] fin_dir;
    logic [`PM_NPINS-1:0] fin_out;
    logic [`PM_NPINS-1:0] fin_die;

    // Either shift state lets the test data pin drive
    logic shifting;

    assign reg_out = {portd_out, portc_out};
    assign reg_dir = {portd_dir, portc_dir};
    assign pad_in = {padd_in, padc_in};
    assign shifting = shift_instr_state | shift_data_state;

    // ****************
    // Override table
    // ****************
    // Pins without an alternate owner keep all enables low.
    always_comb begin
        pullup_override_en = `PM_RST_VEC;
        pullup_override_val = `PM_RST_VEC;
        dir_override_en = `PM_RST_VEC;
        dir_override_val = `PM_RST_VEC;
        outval_override_en = `PM_RST_VEC;
        outval_override_val = `PM_RST_VEC;
        input_enable_override_en = `PM_RST_VEC;
        input_enable_override_val = `PM_RST_VEC;

        // Oscillator pins: released, no pull-up, no digital input
        pullup_override_en[`PM_OSC_OUT] = timer2_async_select;
        dir_override_en[`PM_OSC_OUT] = timer2_async_select;
        input_enable_override_en[`PM_OSC_OUT] = timer2_async_select;
        pullup_override_en[`PM_OSC_IN] = timer2_async_select;
        dir_override_en[`PM_OSC_IN] = timer2_async_select;
        input_enable_override_en[`PM_OSC_IN] = timer2_async_select;

        // Test data in: pulled up input on the analog path
        pullup_override_en[`PM_TDIN] = test_port_enable;
        pullup_override_val[`PM_TDIN] = 1'b1;
        dir_override_en[`PM_TDIN] = test_port_enable;
        input_enable_override_en[`PM_TDIN] = test_port_enable;

        // Test data out: drives only while shifting
        pullup_override_en[`PM_TDOUT] = test_port_enable;
        dir_override_en[`PM_TDOUT] = test_port_enable;
        dir_override_val[`PM_TDOUT] = shifting;
        outval_override_en[`PM_TDOUT] = test_port_enable;
        outval_override_val[`PM_TDOUT] = test_data_out;
        input_enable_override_en[`PM_TDOUT] = test_port_enable;

        // Mode select and test clock: pulled-up inputs
        pullup_override_en[`PM_TMSEL] = test_port_enable;
        pullup_override_val[`PM_TMSEL] = 1'b1;
        dir_override_en[`PM_TMSEL] = test_port_enable;
        input_enable_override_en[`PM_TMSEL] = test_port_enable;
        pullup_override_en[`PM_TCLK] = test_port_enable;
        pullup_override_val[`PM_TCLK] = 1'b1;
        dir_override_en[`PM_TCLK] = test_port_enable;
        input_enable_override_en[`PM_TCLK] = test_port_enable;

        // Two-wire data: open drain, output value pinned low
        pullup_override_en[`PM_SDA] = two_wire_enable;
        pullup_override_val[`PM_SDA] =
            portc_out[`PM_SDA] & ~global_pullup_disable;
        dir_override_en[`PM_SDA] = two_wire_enable;
        dir_override_val[`PM_SDA] = two_wire_data_out;
        outval_override_en[`PM_SDA] = two_wire_enable;

        // Two-wire clock: same open-drain treatment
        pullup_override_en[`PM_SCL] = two_wire_enable;
        pullup_override_val[`PM_SCL] =
            portc_out[`PM_SCL] & ~global_pullup_disable;
        dir_override_en[`PM_SCL] = two_wire_enable;
        dir_override_val[`PM_SCL] = two_wire_clock_out;
        outval_override_en[`PM_SCL] = two_wire_enable;

        // Timer compare outputs replace only the value
        outval_override_en[`PM_CMP2] = timer2_compare_en;
        outval_override_val[`PM_CMP2] = timer2_compare_out;
        outval_override_en[`PM_CMP1A] = timer1_compare_a_en;
        outval_override_val[`PM_CMP1A] = timer1_compare_a_out;
        outval_override_en[`PM_CMP1B] = timer1_compare_b_en;
        outval_override_val[`PM_CMP1B] = timer1_compare_b_out;

        // External interrupts keep the input buffer awake
        input_enable_override_en[`PM_IRQ0] = ext_irq0_en;
        input_enable_override_val[`PM_IRQ0] = 1'b1;
        input_enable_override_en[`PM_IRQ1] = ext_irq1_en;
        input_enable_override_val[`PM_IRQ1] = 1'b1;

        // Transmit pin: forced output, no pull-up
        pullup_override_en[`PM_TXD] = transmitter_enable;
        dir_override_en[`PM_TXD] = transmitter_enable;
        dir_override_val[`PM_TXD] = 1'b1;
        outval_override_en[`PM_TXD] = transmitter_enable;
        outval_override_val[`PM_TXD] = transmit_data;

        // Receive pin: forced input, pull-up from port bit
        pullup_override_en[`PM_RXD] = receiver_enable;
        pullup_override_val[`PM_RXD] =
            portd_out[`PM_RXD - `PM_PORT_W] & ~global_pullup_disable;
        dir_override_en[`PM_RXD] = receiver_enable;
    end

    // ****************
    // Per-pin multiplexers
    // ****************
    // Register defaults: pull-up when input with output bit set,
    // unless the global disable is on; digital input awake.
    always_comb begin
        for (int i = 0; i < `PM_NPINS; i++) begin
            fin_pu[i] = pullup_override_en[i] ? pullup_override_val[i]
                : (reg_out[i] & ~reg_dir[i]
                   & ~global_pullup_disable);
            fin_dir[i] = dir_override_en[i] ? dir_override_val[i]
                : reg_dir[i];
            fin_out[i] = outval_override_en[i] ? outval_override_val[i]
                : reg_out[i];
            fin_die[i] = input_enable_override_en[i]
                ? input_enable_override_val[i] : 1'b1;
        end
    end

    // ****************
    // Next-state logic
    // ****************
    // Two-flop synchroniser, spike filter on the two-wire pins,
    // and registered pad controls. Registering the pads costs one
    // cycle of latency but keeps glitches off the package pins.
    always_comb begin
        logic [`PM_FILT_W-1:0] nxt;
        logic raw;
        nxt = '0;
        raw = 1'b0;
        st_d = st_q;
        st_d.sync1 = pad_in;
        st_d.sync2 = st_q.sync1;

        // Filter: a new level must persist for the spike time
        for (int k = 0; k < 2; k++) begin
            raw = st_q.sync2[k];
            nxt = st_q.twi_cnt[k] + `PM_FILT_W'(1);
            if (!two_wire_enable) begin
                // Bypass while the interface does not own the pin
                st_d.twi_val[k] = raw;
                st_d.twi_cnt[k] = '0;
            end else if (raw == st_q.twi_val[k]) begin
                // Level agrees, any pending change was a spike
                st_d.twi_cnt[k] = '0;
            end else if (nxt >= `PM_FILT_W'(`PM_SPIKE_CYC)) begin
                // Change held long enough, accept it
                st_d.twi_val[k] = raw;
                st_d.twi_cnt[k] = '0;
            end else begin
                // Still counting the run of the new level
                st_d.twi_cnt[k] = nxt;
            end
        end

        st_d.pad_pu = fin_pu;
        st_d.pad_oe = fin_dir;
        st_d.pad_out = fin_out;
        // Disabled input buffers read as zero
        st_d.din = st_q.sync2 & fin_die;
    end

    // ****************
    // State register
    // ****************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_q.sync1 <= `PM_RST_VEC;
            st_q.sync2 <= `PM_RST_VEC;
            st_q.twi_val <= `PM_RST_TWO;
            st_q.twi_cnt <= '0;
            st_q.pad_out <= `PM_RST_VEC;
            st_q.pad_oe <= `PM_RST_VEC;
            st_q.pad_pu <= `PM_RST_VEC;
            st_q.din <= `PM_RST_VEC;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************
    // Pad outputs
    // ****************
    assign padc_out = st_q.pad_out[`PM_PORT_W-1:0];
    assign padc_oe = st_q.pad_oe[`PM_PORT_W-1:0];
    assign padc_pullup = st_q.pad_pu[`PM_PORT_W-1:0];
    assign padd_out = st_q.pad_out[`PM_NPINS-1:`PM_PORT_W];
    assign padd_oe = st_q.pad_oe[`PM_NPINS-1:`PM_PORT_W];
    assign padd_pullup = st_q.pad_pu[`PM_NPINS-1:`PM_PORT_W];
    assign portc_pin = st_q.din[`PM_PORT_W-1:0];
    assign portd_pin = st_q.din[`PM_NPINS-1:`PM_PORT_W];

    // ****************
    // Peripheral inputs
    // ****************
    // Analog-path signals bypass the input-enable gate, so they stay
    // alive while the digital buffer is switched off.
    assign test_clock_in = st_q.sync2[`PM_TCLK];
    assign test_mode_in = st_q.sync2[`PM_TMSEL];
    assign test_data_in = st_q.sync2[`PM_TDIN];
    assign two_wire_data_in = st_q.twi_val[`PM_SDA];
    assign two_wire_clock_in = st_q.twi_val[`PM_SCL];
    assign timer_osc_in = st_q.sync2[`PM_OSC_IN];
    assign timer1_capture_in = st_q.din[`PM_CAPT];
    assign ext_irq0_in = st_q.din[`PM_IRQ0];
    assign ext_irq1_in = st_q.din[`PM_IRQ1];
    assign receive_data = st_q.din[`PM_RXD];

endmodule // pm_port_cd_override

// [pm_cd_props.sv]
// Checker for the port C / D pin override block.
// Assumes it is bound to pm_port_cd_override and sees its ports only.
`timescale 1ns/1ps
module pm_cd_props (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [7:0] portc_out,
    input wire logic [7:0] portd_out,
    input wire logic [7:0] portd_dir,
    input wire logic global_pullup_disable,
    input wire logic timer2_async_select,
    input wire logic test_port_enable,
    input wire logic shift_instr_state,
    input wire logic shift_data_state,
    input wire logic two_wire_enable,
    input wire logic two_wire_data_out,
    input wire logic two_wire_clock_out,
    input wire logic timer2_compare_en,
    input wire logic timer2_compare_out,
    input wire logic transmitter_enable,
    input wire logic transmit_data,
    input wire logic receiver_enable,
    input wire logic test_data_out,
    input wire logic [7:0] padc_out,
    input wire logic [7:0] padc_oe,
    input wire logic [7:0] padc_pullup,
    input wire logic [7:0] padd_out,
    input wire logic [7:0] padd_oe,
    input wire logic [7:0] padd_pullup,
    input wire logic [7:0] padd_in,
    input wire logic timer1_capture_in,
    input wire logic ext_irq0_in
);
    // ****************
    // Pad controls lag their causes by exactly one edge
    // ****************
    // One domain; $past(nrst) masks the first edge after a release
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    chk_txd_drive: assert property ($past(nrst) &&
        $past(transmitter_enable) |-> padd_oe[1] && !padd_pullup[1]
        && padd_out[1] == $past(transmit_data))
        else $error("transmit pin not driven as output");
    chk_rxd_input: assert property ($past(nrst) &&
        $past(receiver_enable) |-> !padd_oe[0] && padd_pullup[0] ==
        $past(portd_out[0] & ~global_pullup_disable))
        else $error("receive pin not an input");
    chk_twi_open_drain: assert property ($past(nrst) &&
        $past(two_wire_enable) |-> padc_out[1:0] == 2'h0 &&
        padc_oe[1:0] == $past({two_wire_data_out, two_wire_clock_out}))
        else $error("two-wire pins not open-drain");
    chk_twi_pullup: assert property ($past(nrst) &&
        $past(two_wire_enable) |-> padc_pullup[1:0] ==
        $past(portc_out[1:0] & ~{2{global_pullup_disable}}))
        else $error("two-wire pull-up wrong");
    chk_osc_release: assert property ($past(nrst) &&
        $past(timer2_async_select) |-> padc_oe[7:6] == 2'h0 &&
        padc_pullup[7:6] == 2'h0)
        else $error("oscillator pins not released");
    chk_test_pins: assert property ($past(nrst) &&
        $past(test_port_enable) |-> padc_pullup[5] && padc_pullup[3] &&
        padc_pullup[2] && !padc_oe[5] && !padc_oe[3] && !padc_oe[2] &&
        padc_oe[4] == $past(shift_instr_state | shift_data_state) &&
        padc_out[4] == $past(test_data_out))
        else $error("test port pins wrong");
    chk_cmp_value: assert property ($past(nrst) &&
        $past(timer2_compare_en) |-> padd_out[7] ==
        $past(timer2_compare_out) && padd_oe[7] == $past(portd_dir[7]))
        else $error("compare output not on pin");
    chk_pud_off: assert property ($past(nrst) &&
        $past(global_pullup_disable) && !$past(test_port_enable) |->
        padc_pullup == 8'h00 && padd_pullup == 8'h00)
        else $error("pull-up on while disabled");
    chk_plain_pin: assert property ($past(nrst) |->
        padd_oe[6] == $past(portd_dir[6]) && padd_out[6] ==
        $past(portd_out[6]) && padd_pullup[6] == $past(portd_out[6] &
        ~portd_dir[6] & ~global_pullup_disable))
        else $error("plain pin not following registers");
    // Pin inputs need at most four edges once the pad stands still
    chk_capture_path: assert property (
        (nrst && $stable(padd_in[6])) [*5] |->
        timer1_capture_in == padd_in[6])
        else $error("capture input not following pin");
    chk_irq_path: assert property (
        (nrst && $stable(padd_in[2])) [*5] |-> ext_irq0_in == padd_in[2])
        else $error("interrupt input not following pin");
    cover property (two_wire_enable && padc_oe[1]);
    cover property (test_port_enable && padc_oe[4]);
    cover property (transmitter_enable && receiver_enable);
endmodule // pm_cd_props

bind pm_port_cd_override pm_cd_props pm_cd_props_inst (.*);

// [pm_pad_model.sv]
// Pad model standing in for the package pins and the board.
// Assumes the bench drives ext_* and the block drives dev_*.
`timescale 1ns/1ps
module pm_pad_model (
    input wire logic clk_sys,
    input wire logic [15:0] dev_out,
    input wire logic [15:0] dev_oe,
    input wire logic [15:0] dev_pu,
    input wire logic [15:0] ext_val,
    input wire logic [15:0] ext_oe,
    output logic [15:0] pad_lvl
);
    logic [15:0] last_q = 16'h0000; // Level seen at the last edge
    // Device drive wins, then the board, then the pull-up; a line
    // nobody holds flips, so no check leans on a settled unknown
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (dev_oe[i]) begin
                pad_lvl[i] = dev_out[i];
            end else if (ext_oe[i]) begin
                pad_lvl[i] = ext_val[i];
            end else begin
                pad_lvl[i] = dev_pu[i] | ~last_q[i];
            end
        end
    end
    // Remember the level for the floating case
    always @(posedge clk_sys) begin
        last_q <= pad_lvl;
    end
endmodule // pm_pad_model

// [test_pm_port_cd_override.sv]
// Self-checking bench for the port C / D override block.
// Assumes the pad model and the bound checker are compiled first.
`timescale 1ns/1ps
module test_pm_port_cd_override;
    logic clk_sys = 1'b0;
    logic nrst;
    logic [7:0] portc_out, portc_dir, portd_out, portd_dir;
    logic global_pullup_disable, timer2_async_select, test_port_enable;
    logic shift_instr_state, shift_data_state, two_wire_enable;
    logic timer2_compare_en, timer1_compare_a_en, timer1_compare_b_en;
    logic ext_irq0_en, ext_irq1_en, transmitter_enable, receiver_enable;
    logic test_data_out, two_wire_data_out, two_wire_clock_out;
    logic timer2_compare_out, timer1_compare_a_out, timer1_compare_b_out;
    logic transmit_data;
    logic [7:0] padc_in, padd_in, padc_out, padc_oe, padc_pullup;
    logic [7:0] padd_out, padd_oe, padd_pullup, portc_pin, portd_pin;
    logic test_clock_in, test_mode_in, test_data_in, two_wire_data_in;
    logic two_wire_clock_in, timer_osc_in, timer1_capture_in;
    logic ext_irq0_in, ext_irq1_in, receive_data;
    logic [15:0] ext_val, ext_oe, pad_lvl;
    int failures = 0;
    int checks_done = 0;
    assign padc_in = pad_lvl[7:0];
    assign padd_in = pad_lvl[15:8];

    always #12.5 clk_sys = ~clk_sys; // 40 MHz

    pm_port_cd_override pm_port_cd_override_inst (.*);
    pm_pad_model pm_pad_model_inst (.clk_sys,
        .dev_out({padd_out, padc_out}), .dev_oe({padd_oe, padc_oe}),
        .dev_pu({padd_pullup, padc_pullup}), .ext_val, .ext_oe, .pad_lvl);

    // ****************
    // Shared tasks
    // ****************
    // Every block input but clock and reset, and every board drive, back to zero
    task automatic zero_inputs;
        {portc_out, portc_dir, portd_out, portd_dir, global_pullup_disable,
         timer2_async_select, test_port_enable, shift_instr_state,
         shift_data_state, two_wire_enable, timer2_compare_en,
         timer1_compare_a_en, timer1_compare_b_en, ext_irq0_en,
         ext_irq1_en, transmitter_enable, receiver_enable, test_data_out,
         two_wire_data_out, two_wire_clock_out, timer2_compare_out,
         timer1_compare_a_out, timer1_compare_b_out, transmit_data,
         ext_val, ext_oe} = '0;
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic idle;
        @(negedge clk_sys);
        zero_inputs();
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ****************
    // Scenarios
    // ****************
    // Plain port pins, then the global pull-up disable
    task automatic t_plain;
        idle();
        portd_out = 8'hf0;
        portd_dir = 8'h30;
        portc_out = 8'h0f;
        portc_dir = 8'h05;
        step(2);
        check(padd_pullup, 8'hc0);
        check(padd_oe, 8'h30);
        check(padd_out, 8'hf0);
        check(padc_pullup, 8'h0a);
        global_pullup_disable = 1'b1;
        step(2);
        check(padd_pullup | padc_pullup, 8'h00);
    endtask
    // Open-drain lines, pull-ups and the spike filter
    task automatic t_two_wire;
        idle();
        two_wire_enable = 1'b1;
        portc_out = 8'h03;
        two_wire_data_out = 1'b1;
        step(2);
        check(padc_oe & 8'h03, 8'h02);
        check(padc_out & 8'h03, 8'h00);
        check(padc_pullup & 8'h03, 8'h03);
        two_wire_data_out = 1'b0;
        two_wire_clock_out = 1'b1;
        step(6);
        check({7'h0, two_wire_clock_in}, 8'h00);
        check({7'h0, two_wire_data_in}, 8'h01);
        ext_oe[1] = 1'b1; // One-cycle low spike from the bus
        step(1);
        ext_oe[1] = 1'b0;
        step(6);
        check({7'h0, two_wire_data_in}, 8'h01);
        ext_oe[1] = 1'b1;
        step(6);
        check({7'h0, two_wire_data_in}, 8'h00);
        portc_out = 8'h02;
        step(2);
        check(padc_pullup & 8'h03, 8'h02);
    endtask
    // Oscillator pins leave the port
    task automatic t_osc;
        idle();
        timer2_async_select = 1'b1;
        portc_out = 8'hff;
        portc_dir = 8'h40;
        ext_oe[6] = 1'b1; // Crystal side holds the input high
        ext_val[6] = 1'b1;
        step(4);
        check(padc_oe, 8'h00);
        check(padc_pullup, 8'h3f);
        check({7'h0, timer_osc_in}, 8'h01);
        check(portc_pin & 8'hc0, 8'h00);
    endtask
    // Test port pins across all shift-state combinations
    task automatic t_test_port;
        idle();
        test_port_enable = 1'b1;
        global_pullup_disable = 1'b1;
        portc_dir = 8'h3c;
        test_data_out = 1'b1;
        ext_oe[2] = 1'b1;
        ext_val[2] = 1'b1;
        for (int i = 0; i < 4; i++) begin
            {shift_instr_state, shift_data_state} = i[1:0];
            step(2);
            check(padc_oe & 8'h3c, (i != 0) ? 8'h10 : 8'h00);
            check(padc_pullup & 8'h3c, 8'h2c);
            check(padc_out & 8'h10, 8'h10);
        end
        step(4);
        check({7'h0, test_clock_in}, 8'h01);
        check({6'h0, test_mode_in, test_data_in}, 8'h03);
        check(portc_pin & 8'h0c, 8'h00);
        ext_val[2] = 1'b0;
        step(4);
        check({7'h0, test_clock_in}, 8'h00);
    endtask
    // Compare outputs and the capture input on port D
    task automatic t_timers;
        idle();
        portd_dir = 8'hb0;
        portd_out = 8'h20;
        {timer2_compare_en, timer1_compare_a_en, timer1_compare_b_en} = '1;
        timer2_compare_out = 1'b1;
        timer1_compare_b_out = 1'b1;
        ext_oe[14] = 1'b1;
        ext_val[14] = 1'b1;
        step(6);
        check(padd_out & 8'hb0, 8'h90);
        check(padd_oe & 8'hb0, 8'hb0);
        check({7'h0, timer1_capture_in}, 8'h01);
        timer1_compare_b_en = 1'b0;
        ext_val[14] = 1'b0;
        step(6);
        check(padd_out & 8'hb0, 8'h80);
        check({7'h0, timer1_capture_in}, 8'h00);
    endtask
    // Serial transmit and receive pins, external interrupt inputs
    task automatic t_uart_irq;
        idle();
        {transmitter_enable, receiver_enable, ext_irq0_en} = '1;
        ext_irq1_en = 1'b1;
        portd_dir = 8'h01;
        portd_out = 8'h03;
        transmit_data = 1'b1;
        ext_oe = 16'h0d00;
        ext_val = 16'h0c00;
        step(6);
        check(padd_oe & 8'h03, 8'h02);
        check(padd_out & 8'h02, 8'h02);
        check(padd_pullup & 8'h03, 8'h01);
        check({7'h0, receive_data}, 8'h00);
        check({6'h0, ext_irq1_in, ext_irq0_in}, 8'h03);
        check(portd_pin & 8'h0d, 8'h0c);
        global_pullup_disable = 1'b1;
        transmit_data = 1'b0;
        ext_val = 16'h0100;
        step(6);
        check(padd_pullup & 8'h03, 8'h00);
        check(padd_out & 8'h02, 8'h00);
        check({7'h0, receive_data}, 8'h01);
        check({6'h0, ext_irq1_in, ext_irq0_in}, 8'h00);
        check(portd_pin & 8'h0d, 8'h01);
    endtask

    // ****************
    // Main sequence and watchdog
    // ****************
    initial begin
        nrst = 1'b0;
        zero_inputs();
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        nrst = 1'b1;
        step(2);
        t_plain();
        t_two_wire();
        t_osc();
        t_test_port();
        t_timers();
        t_uart_irq();
        give_verdict();
    end
    // The run needs some 85 cycles; 4000 means a hang
    initial begin
        #100000;
        failures++;
        give_verdict();
    end
endmodule // test_pm_port_cd_override
